// File: include/dac_if_pkg.sv
// Shared constants, types and states of the two-wire converter front end
package dac_if_pkg;

    localparam int        BYTE_BITS      = 8;
    localparam int        CODE_BITS      = 10;
    localparam int        ADDR_BITS      = 7;
    localparam logic [3:0] BIT_CNT_ACK    = 4'h8;
    localparam logic [3:0] BIT_CNT_LAST   = 4'h7;

    // Slave addresses
    localparam logic [3:0] OWN_ADDR_UPPER = 4'h4;
    localparam logic [6:0] FIXED_ADDR     = 7'h20;
    localparam logic [6:0] SYNC_ADDR      = 7'h7E;

    // Command byte field positions
    localparam int        CMD_DEFERRED   = 0;
    localparam int        CMD_POWER_DOWN = 1;
    localparam int        CMD_INT_REF    = 2;

    // High data byte field
    localparam int        HI_CODE_MSB    = 1;

    // Reset values
    localparam logic [7:0] COMMAND_RESET  = 8'h00;
    localparam logic [7:0] CODE_LOW_RESET = 8'h00;
    localparam logic [7:0] CODE_HI_RESET  = 8'h00;
    localparam logic [9:0] CODE_RESET     = 10'h000;

    typedef struct packed {
        logic       power_down;
        logic       internal_ref;
        logic [9:0] code;
    } dac_out_s;

    localparam dac_out_s DAC_OUT_RESET = '{power_down: 1'b0, internal_ref: 1'b0,
                                           code: CODE_RESET};

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_LO,
        ST_HI,
        ST_DONE,
        ST_IGNORE
    } rx_state_e;

endpackage

// File: rtl/scl_byte_shifter.sv
// Serial-clock domain bit shifter that hands each received byte to the core
`timescale 1ns/1ps
module scl_byte_shifter #(
    parameter int BYTE_W = dac_if_pkg::BYTE_BITS
) (
    input  wire logic              scl,
    input  wire logic              frame_rst,
    input  wire logic              rst,
    input  wire logic              sda_in,
    output logic [BYTE_W-1:0]      byte_q,
    output logic                   byte_toggle_q
);

    generate
        if (BYTE_W != 8)
        begin : g_width_check
            $error("scl_byte_shifter supports only 8-bit bytes");
        end
    endgenerate

    logic [3:0]        cnt_q;
    logic [BYTE_W-1:0] shift_q;
    logic [BYTE_W-1:0] next_shift;

    assign next_shift = {shift_q[BYTE_W-2:0], sda_in};

    // Frame reset realigns the count at every start or stop
    always_ff @(posedge scl or posedge frame_rst)
    begin
        if (frame_rst)
            cnt_q <= 4'h0;
        else if (cnt_q == dac_if_pkg::BIT_CNT_ACK)
            cnt_q <= 4'h0;
        else
            cnt_q <= cnt_q + 4'h1;
    end

    // Data sampled on the rising clock edge
    always_ff @(posedge scl or posedge frame_rst)
    begin
        if (frame_rst)
            shift_q <= '0;
        else if (cnt_q != dac_if_pkg::BIT_CNT_ACK)
            shift_q <= next_shift; // RULE26
    end

    // Toggle is not frame reset, or the core would see a false byte
    always_ff @(posedge scl or posedge rst)
    begin
        if (rst)
        begin
            byte_q        <= '0;
            byte_toggle_q <= 1'b0;
        end
        else if (!frame_rst && cnt_q == dac_if_pkg::BIT_CNT_LAST)
        begin
            byte_q        <= next_shift;
            byte_toggle_q <= ~byte_toggle_q;
        end
    end

endmodule

// File: rtl/smbus_dac_write_slave.sv
// Receive-only two-wire slave front end of a 10-bit voltage converter
// Overview of operation
// [RULE1] Master leaves both lines released high while the bus is idle.
// [RULE2] Data falling while clock high is a start; it opens a transaction.
// [RULE3] Data rising while clock high is a stop; it ends a transaction.
// [RULE4] Device only receives; it never drives data bytes.
// [RULE5] Master clocks each acknowledge bit and releases data during it.
// [RULE6] Device pulls data low through the whole acknowledge clock high phase.
// [RULE7] Write word: start, address, write zero, command, low, high, stop.
// [RULE8] Command byte is latched into its input register on acknowledge.
// [RULE9] Low then high data bytes go to their input registers on acknowledge.
// [RULE10] Without deferred mode, stop copies input registers to output latches.
// [RULE11] Own address is 0100 plus three address-select pins.
// [RULE12] Five-pin variant uses fixed address 0100 000.
// [RULE13] Command bit 0 chooses update on sync acknowledge or on stop.
// [RULE14] Deferred update happens at the sync acknowledge rising clock edge.
// [RULE15] Command bit 1 requests power-down; zero means normal operation.
// [RULE16] Power-down applies at stop, keeps latches, floats the output.
// [RULE17] Command bit 2 selects internal reference; bits 7 to 3 ignored.
// [RULE18] First data byte holds code bits 7 to 0.
// [RULE19] Second data byte holds code bits 9 and 8 in bits 1 and 0.
// [RULE20] Send byte carries only a command and updates no data.
// [RULE21] Interruption between command and last data ack drops data, keeps command.
// [RULE22] Interruption before command acknowledge drops the partial command.
// [RULE23] Device also answers the shared sync address 1111 110.
// [RULE24] Sync quick command with write bit clears all latches at acknowledge.
// [RULE25] Sync quick command with read bit updates outputs only in deferred mode.
// [RULE26] Data line is sampled on rising clock edges.
// [RULE27] Unmatched address is not acknowledged; rest of transaction ignored.
// [RULE28] Power-on clears all registers: zero code, stop update, normal, supply.
`timescale 1ns/1ps
module smbus_dac_write_slave #(
    parameter bit FIVE_PIN = 1'b0
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic                  scl,
    input  wire logic                  sda_in,
    output logic                       sda_out,
    output logic                       sda_oe_n,
    input  wire logic                  slave_id_pin_2,
    input  wire logic                  slave_id_pin_1,
    input  wire logic                  slave_id_pin_0,
    output dac_if_pkg::dac_out_s       dac_out,
    output logic                       deferred_latch_select
);

    logic [2:0]                id_meta_q;
    logic [2:0]                id_s_q;
    logic                      scl_meta_q;
    logic                      scl_s_q;
    logic                      scl_p_q;
    logic                      sda_meta_q;
    logic                      sda_s_q;
    logic                      sda_p_q;
    logic                      tog_meta_q;
    logic                      tog_s_q;
    logic                      tog_p_q;
    logic                      restart_q;
    logic                      frame_rst;
    logic [7:0]                link_byte;
    logic                      link_toggle;
    logic [7:0]                rx_byte_q;
    logic                      start_ev;
    logic                      stop_ev;
    logic                      byte_ev;
    logic                      scl_rise;
    logic                      scl_fall;
    logic                      ack_rise;
    logic                      ack_arm_q;
    logic                      sda_oe_n_q;
    logic                      ack_decide;
    logic [6:0]                own_addr;
    dac_if_pkg::rx_state_e     state_q;
    logic                      addressed_q;
    logic [7:0]                command_input_q;
    logic [7:0]                code_low_input_q;
    logic [7:0]                code_high_input_q;
    logic [7:0]                low_saved_q;
    dac_if_pkg::dac_out_s      out_q;
    logic [9:0]                staged_code;

    function automatic logic is_own(input logic [7:0] b, input logic [6:0] a);
        is_own = (b[7:1] == a);
    endfunction

    function automatic logic is_sync(input logic [7:0] b);
        is_sync = (b[7:1] == dac_if_pkg::SYNC_ADDR);
    endfunction

    // Strap pins are caught through two flops, never at reset
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            id_meta_q <= 3'h0;
            id_s_q    <= 3'h0;
        end
        else
        begin
            id_meta_q <= {slave_id_pin_2, slave_id_pin_1, slave_id_pin_0};
            id_s_q    <= id_meta_q;
        end
    end

    assign own_addr = FIVE_PIN ? dac_if_pkg::FIXED_ADDR // RULE12
                               : {dac_if_pkg::OWN_ADDR_UPPER, id_s_q}; // RULE11

    // Bus line synchronisers; idle lines read high
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            scl_meta_q <= 1'b1;
            scl_s_q    <= 1'b1;
            scl_p_q    <= 1'b1;
            sda_meta_q <= 1'b1;
            sda_s_q    <= 1'b1;
            sda_p_q    <= 1'b1;
        end
        else
        begin
            scl_meta_q <= scl;
            scl_s_q    <= scl_meta_q;
            scl_p_q    <= scl_s_q;
            sda_meta_q <= sda_in;
            sda_s_q    <= sda_meta_q;
            sda_p_q    <= sda_s_q;
        end
    end

    assign start_ev = scl_s_q && scl_p_q && sda_p_q && !sda_s_q; // RULE2
    assign stop_ev  = scl_s_q && scl_p_q && !sda_p_q && sda_s_q; // RULE3
    assign scl_rise = scl_s_q && !scl_p_q;
    assign scl_fall = !scl_s_q && scl_p_q;
    assign ack_rise = scl_rise && !sda_oe_n_q;

    // Byte hand-over toggle from the clock-line domain
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            tog_meta_q <= 1'b0;
            tog_s_q    <= 1'b0;
            tog_p_q    <= 1'b0;
        end
        else
        begin
            tog_meta_q <= link_toggle;
            tog_s_q    <= tog_meta_q;
            tog_p_q    <= tog_s_q;
        end
    end

    assign byte_ev = tog_s_q ^ tog_p_q;

    // Byte word is stable for a whole byte time once the toggle is seen
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            rx_byte_q <= 8'h00;
        else if (byte_ev)
            rx_byte_q <= link_byte;
    end

    // Held until the clock line reads low so the count restarts cleanly
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            restart_q <= 1'b1;
        else if (start_ev || stop_ev)
            restart_q <= 1'b1;
        else if (!scl_s_q)
            restart_q <= 1'b0;
    end

    assign frame_rst = rst | restart_q;

    scl_byte_shifter #(
        .BYTE_W (dac_if_pkg::BYTE_BITS)
    ) u_shifter (
        .scl           (scl),
        .frame_rst     (frame_rst),
        .rst           (rst),
        .sda_in        (sda_in),
        .byte_q        (link_byte),
        .byte_toggle_q (link_toggle)
    );

    // Acknowledge decision per received byte
    always_comb
    begin
        ack_decide = 1'b0;
        case (state_q)
            dac_if_pkg::ST_ADDR:
                ack_decide = (is_own(link_byte, own_addr) && !link_byte[0]) // RULE7
                             || is_sync(link_byte); // RULE23 RULE27
            dac_if_pkg::ST_CMD,
            dac_if_pkg::ST_LO,
            dac_if_pkg::ST_HI:
                ack_decide = 1'b1;
            default:
                ack_decide = 1'b0; // RULE4
        endcase
    end

    // Drive low from the falling edge after bit 8 to the next falling edge
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ack_arm_q  <= 1'b0;
            sda_oe_n_q <= 1'b1;
        end
        else if (start_ev || stop_ev)
        begin
            ack_arm_q  <= 1'b0;
            sda_oe_n_q <= 1'b1;
        end
        else if (byte_ev)
            ack_arm_q <= ack_decide;
        else if (scl_fall && ack_arm_q)
        begin
            ack_arm_q  <= 1'b0;
            sda_oe_n_q <= 1'b0; // RULE6
        end
        else if (scl_fall)
            sda_oe_n_q <= 1'b1; // RULE6
    end

    assign sda_out  = 1'b0;
    assign sda_oe_n = sda_oe_n_q;

    // Transaction sequencing; commits happen at the acknowledge rising edge
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            state_q <= dac_if_pkg::ST_IDLE;
        else if (start_ev)
            state_q <= dac_if_pkg::ST_ADDR; // RULE2
        else if (stop_ev)
            state_q <= dac_if_pkg::ST_IDLE; // RULE3
        else if (byte_ev && !ack_decide && state_q == dac_if_pkg::ST_ADDR)
            state_q <= dac_if_pkg::ST_IGNORE; // RULE27
        else if (ack_rise)
        begin
            case (state_q)
                dac_if_pkg::ST_ADDR:
                    state_q <= is_sync(rx_byte_q) ? dac_if_pkg::ST_DONE
                                                  : dac_if_pkg::ST_CMD;
                dac_if_pkg::ST_CMD:
                    state_q <= dac_if_pkg::ST_LO;
                dac_if_pkg::ST_LO:
                    state_q <= dac_if_pkg::ST_HI;
                dac_if_pkg::ST_HI:
                    state_q <= dac_if_pkg::ST_DONE;
                default:
                    state_q <= state_q;
            endcase
        end
    end

    // Own write address seen in this frame
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            addressed_q <= 1'b0;
        else if (start_ev || stop_ev)
            addressed_q <= 1'b0;
        else if (ack_rise && state_q == dac_if_pkg::ST_ADDR && !is_sync(rx_byte_q))
            addressed_q <= 1'b1;
    end

    // A stop while the high byte is pending must not commit the dropped low byte
    assign staged_code = {code_high_input_q[dac_if_pkg::HI_CODE_MSB:0],
                          (state_q == dac_if_pkg::ST_HI) ? low_saved_q
                                                         : code_low_input_q}; // RULE18 RULE19 RULE21

    // Input registers; a partial byte never reaches them
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            command_input_q   <= dac_if_pkg::COMMAND_RESET; // RULE28
            code_low_input_q  <= dac_if_pkg::CODE_LOW_RESET;
            code_high_input_q <= dac_if_pkg::CODE_HI_RESET;
            low_saved_q       <= dac_if_pkg::CODE_LOW_RESET;
        end
        else if ((start_ev || stop_ev) && state_q == dac_if_pkg::ST_HI)
            code_low_input_q <= low_saved_q; // RULE21 RULE20
        else if (ack_rise)
        begin
            case (state_q)
                dac_if_pkg::ST_ADDR:
                    if (is_sync(rx_byte_q) && !rx_byte_q[0])
                    begin
                        command_input_q   <= dac_if_pkg::COMMAND_RESET; // RULE24
                        code_low_input_q  <= dac_if_pkg::CODE_LOW_RESET;
                        code_high_input_q <= dac_if_pkg::CODE_HI_RESET;
                        low_saved_q       <= dac_if_pkg::CODE_LOW_RESET;
                    end
                dac_if_pkg::ST_CMD:
                    command_input_q <= rx_byte_q; // RULE8 RULE22
                dac_if_pkg::ST_LO:
                begin
                    low_saved_q      <= code_low_input_q;
                    code_low_input_q <= rx_byte_q; // RULE9
                end
                dac_if_pkg::ST_HI:
                    code_high_input_q <= rx_byte_q; // RULE9
                default:
                    low_saved_q <= low_saved_q;
            endcase
        end
    end

    // Output latches; bits 7 to 3 of the command never reach them
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            out_q <= dac_if_pkg::DAC_OUT_RESET; // RULE28
        else if (ack_rise && state_q == dac_if_pkg::ST_ADDR && is_sync(rx_byte_q))
        begin
            if (!rx_byte_q[0])
                out_q <= dac_if_pkg::DAC_OUT_RESET; // RULE24
            else if (command_input_q[dac_if_pkg::CMD_DEFERRED])
            begin
                out_q.code         <= staged_code; // RULE14 RULE25
                out_q.internal_ref <= command_input_q[dac_if_pkg::CMD_INT_REF];
            end
        end
        else if (stop_ev && addressed_q)
        begin
            out_q.power_down <= command_input_q[dac_if_pkg::CMD_POWER_DOWN]; // RULE15 RULE16
            if (!command_input_q[dac_if_pkg::CMD_DEFERRED]) // RULE13
            begin
                out_q.code         <= staged_code; // RULE10
                out_q.internal_ref <= command_input_q[dac_if_pkg::CMD_INT_REF]; // RULE17
            end
        end
    end

    // Power-down keeps code and reference; the analog side floats the output
    assign dac_out               = out_q;
    assign deferred_latch_select = command_input_q[dac_if_pkg::CMD_DEFERRED];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_ack_begin;
        ack_arm_q && scl_fall && !start_ev && !stop_ev;
    endsequence

    sequence s_ack_driving;
        !sda_oe_n_q && !ack_arm_q;
    endsequence

    chk_start_addr: assert property (start_ev |=> state_q == dac_if_pkg::ST_ADDR) // RULE2
        else $error("start did not open an address phase");

    chk_stop_idle: assert property (stop_ev && !start_ev |=> state_q == dac_if_pkg::ST_IDLE) // RULE3
        else $error("stop did not end the transaction");

    chk_ack_begin: assert property (s_ack_begin |=> s_ack_driving) // RULE6
        else $error("acknowledge not driven after clock fall");

    chk_ack_hold: assert property (!sda_oe_n_q && scl_s_q && !stop_ev && !start_ev
                                   |=> !sda_oe_n_q || !scl_p_q) // RULE6
        else $error("acknowledge released during clock high");

    chk_addr_nack: assert property (byte_ev && state_q == dac_if_pkg::ST_ADDR
                                    && !is_own(link_byte, own_addr) && !is_sync(link_byte)
                                    |=> !ack_arm_q && state_q == dac_if_pkg::ST_IGNORE) // RULE27
        else $error("unmatched address acknowledged");

    chk_cmd_latch: assert property (ack_rise && state_q == dac_if_pkg::ST_CMD && !rst
                                    |=> command_input_q == $past(rx_byte_q)) // RULE8
        else $error("command byte not latched at acknowledge");

    chk_stop_update: assert property (stop_ev && addressed_q
                                      && !command_input_q[dac_if_pkg::CMD_DEFERRED]
                                      |=> out_q.code == $past(staged_code)) // RULE10
        else $error("stop did not update the output code");

    chk_deferred_hold: assert property (stop_ev && command_input_q[dac_if_pkg::CMD_DEFERRED]
                                        |=> $stable(out_q.code)) // RULE13
        else $error("deferred mode updated on stop");

    chk_sync_clear: assert property (ack_rise && state_q == dac_if_pkg::ST_ADDR
                                     && is_sync(rx_byte_q) && !rx_byte_q[0]
                                     |=> out_q == dac_if_pkg::DAC_OUT_RESET
                                         && command_input_q == dac_if_pkg::COMMAND_RESET) // RULE24
        else $error("sync write quick command did not clear");

    chk_drop_low: assert property ((start_ev || stop_ev) && state_q == dac_if_pkg::ST_HI
                                   |=> code_low_input_q == $past(low_saved_q)) // RULE21
        else $error("interrupted write kept its data");

    chk_never_drive: assert property ($fell(sda_oe_n_q)
                                      |-> $past(ack_arm_q) && $past(scl_fall)) // RULE4
        else $error("data line driven outside an acknowledge");

endmodule

// File: sim/bus_master_model.sv
// Two-wire bus master model that drives frames at a 48 ns serial clock
`timescale 1ns/1ps
module bus_master_model (
    output logic scl,
    output logic sda_rel,
    input  wire logic sda
);
    // Clock stands high between frames; data released to the pull-up
    initial
    begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    task automatic start_cond();
        #12 sda_rel = 1'b1;
        #12 scl = 1'b1;
        #24 sda_rel = 1'b0;
        #24 scl = 1'b0;
        #24;
    endtask

    task automatic stop_cond();
        #12 sda_rel = 1'b0;
        #12 scl = 1'b1;
        #24 sda_rel = 1'b1;
        #48;
    endtask

    // Fewer than eight bits leaves the byte cut short with no ack slot
    task automatic put_byte(input logic [7:0] b, input int nbits, output logic ack);
        ack = 1'b0;
        for (int i = 7; i > 7 - nbits; i--)
        begin
            #12 sda_rel = b[i];
            #12 scl = 1'b1;
            #24 scl = 1'b0;
        end
        if (nbits == 8)
        begin
            #12 sda_rel = 1'b1;
            #12 scl = 1'b1;
            #12 ack = !sda;
            #12 scl = 1'b0;
        end
    endtask
endmodule

// File: sim/smbus_dac_write_slave_bench.sv
// Self-checking bench of the converter front end against a reference model
`timescale 1ns/1ps
module smbus_dac_write_slave_bench;
    logic                 core_clk;
    logic                 rst;
    logic                 scl;
    logic                 sda_rel;
    logic                 sda_in;
    logic                 sda_out;
    logic                 sda_oe_n;
    logic [2:0]           id_pins;
    dac_if_pkg::dac_out_s dac_out;
    logic                 deferred_latch_select;
    int                   num_errors;
    int                   cmp_count;
    logic [7:0]           cmd_m;
    logic [7:0]           lo_m;
    logic [7:0]           hi_m;
    logic [9:0]           code_m;
    logic                 ref_m;
    logic                 pd_m;

    // Wired-and of both open-drain parties with the pull-up
    assign sda_in = sda_rel & (sda_oe_n | sda_out);

    bus_master_model u_master (
        .scl     (scl),
        .sda_rel (sda_rel),
        .sda     (sda_in)
    );

    smbus_dac_write_slave u_dut (
        .core_clk              (core_clk),
        .rst                   (rst),
        .scl                   (scl),
        .sda_in                (sda_in),
        .sda_out               (sda_out),
        .sda_oe_n              (sda_oe_n),
        .slave_id_pin_2        (id_pins[2]),
        .slave_id_pin_1        (id_pins[1]),
        .slave_id_pin_0        (id_pins[0]),
        .dac_out               (dac_out),
        .deferred_latch_select (deferred_latch_select)
    );

    initial core_clk = 1'b0;
    always #2 core_clk = ~core_clk;

    task automatic check(input logic [11:0] seen, input logic [11:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            num_errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask

    task automatic check_out();
        check(dac_out, {pd_m, ref_m, code_m});
        check({11'h000, deferred_latch_select}, {11'h000, cmd_m[0]});
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Address byte, nb whole bytes of d (command first), part bits of the next, stop
    task automatic frame(input logic [6:0] a, input logic rw, input logic [23:0] d,
                         input int nb, input int part);
        logic ack;
        logic hit;
        // Bus edges kept off the core sampling edge; strap update settled
        @(negedge core_clk);
        hit = (a === {dac_if_pkg::OWN_ADDR_UPPER, id_pins}) && !rw;
        u_master.start_cond();
        u_master.put_byte({a, rw}, 8, ack);
        check({11'h000, ack}, {11'h000, hit});
        for (int i = 0; i < nb; i++)
        begin
            u_master.put_byte(d[23 - 8 * i -: 8], 8, ack);
            check({11'h000, ack}, {11'h000, hit});
        end
        if (part > 0)
            u_master.put_byte(d[23 - 8 * nb -: 8], part, ack);
        u_master.stop_cond();
        if (hit && nb > 0)
        begin
            cmd_m = d[23:16];
            if (nb == 3)
            begin
                lo_m = d[15:8];
                hi_m = d[7:0];
            end
            pd_m = cmd_m[1];
            if (!cmd_m[0])
            begin
                code_m = {hi_m[1:0], lo_m};
                ref_m = cmd_m[2];
            end
        end
        check_out();
    endtask

    task automatic sync_cmd(input logic rw);
        logic ack;
        @(negedge core_clk);
        u_master.start_cond();
        u_master.put_byte({dac_if_pkg::SYNC_ADDR, rw}, 8, ack);
        check({11'h000, ack}, 12'h001);
        u_master.stop_cond();
        if (!rw)
        begin
            {cmd_m, lo_m, hi_m, code_m, ref_m, pd_m} = '0;
        end
        else if (cmd_m[0])
        begin
            code_m = {hi_m[1:0], lo_m};
            ref_m = cmd_m[2];
        end
        check_out();
    endtask

    initial
    begin
        repeat (100000) @(posedge core_clk);
        num_errors++;
        test_done();
    end

    initial
    begin
        logic [23:0] d;
        num_errors = 0;
        cmp_count = 0;
        rst = 1'b1;
        id_pins = 3'h0;
        {cmd_m, lo_m, hi_m, code_m, ref_m, pd_m} = '0;
        void'($urandom(65));
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        check_out();
        check({11'h000, sda_oe_n}, 12'h001);
        repeat (4) @(posedge core_clk);
        for (int s = 0; s < 8; s++)
        begin
            @(posedge core_clk);
            id_pins <= 3'(s);
            d = 24'($urandom());
            d[16] = 1'b0;
            frame({4'h4, 3'(s)}, 1'b0, d, 3, 0);
            frame({4'h4, 3'(s) ^ 3'h1}, 1'b0, 24'($urandom()), 3, 0);
        end
        frame({4'h4, id_pins}, 1'b1, 24'($urandom()), 3, 0);
        frame({4'h4, id_pins}, 1'b0, 24'h04_0000, 1, 0);
        d = 24'($urandom());
        d[16] = 1'b0;
        frame({4'h4, id_pins}, 1'b0, d, 2, 0);
        frame({4'h4, id_pins}, 1'b0, d, 1, 5);
        frame({4'h4, id_pins}, 1'b0, 24'hFF_0000, 0, 4);
        frame({4'h4, id_pins}, 1'b0, {8'h07, 16'($urandom())}, 3, 0);
        sync_cmd(1'b1);
        sync_cmd(1'b0);
        sync_cmd(1'b1);
        test_done();
    end
endmodule
